// File: qpc_pkg.sv
// Package for the quadrature position counter: widths, reset values, modes.
// Assumes a single 100 MHz system clock domain.
package qpc_pkg;

  // ---------------------------------------------------------------------
  // Counter modes
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    QPC_RESET_ON_INDEX       = 2'b00,
    QPC_RESET_ON_MAX         = 2'b01,
    QPC_RESET_ON_FIRST_INDEX = 2'b10
  } qpc_mode_t;

  // ---------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------
  localparam int          QPC_POS_W        = 32;
  localparam int          QPC_TMR_W        = 32;
  localparam int          QPC_CAP_W        = 16;
  localparam int          QPC_SYNC_W       = 16;
  localparam int          QPC_PRESCALE_W   = 4;
  localparam int          QPC_CAPDIV_W     = 3;
  localparam logic [15:0] QPC_CAP_MAX      = 16'hFFFF;
  localparam logic [31:0] QPC_POS_RESET    = 32'h0000_0000;
  localparam logic [15:0] QPC_CAP_RESET    = 16'h0000;
  localparam int          QPC_SYNC_STAGES  = 2;

endpackage : qpc_pkg

// File: qpc_pulse_stretch.sv
// Pulse stretcher for the compare sync output.
// Assumes the trigger is a one-cycle pulse on the same clock.
module qpc_pulse_stretch
  import qpc_pkg::*;
#(
  parameter int WIDTH = QPC_SYNC_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Trigger and length
  input  wire logic             trigger,
  input  wire logic [WIDTH-1:0] pulse_len,
  // Output
  output logic                  pulse
);

  initial begin
    if (WIDTH < 2) begin
      $error("qpc_pulse_stretch: WIDTH must be at least 2.");
    end
  end

  logic [WIDTH-1:0] remain;
  wire              running = (remain != '0);

  // A new trigger reloads the count, so the pulse always lasts the full width.
  always_ff @(posedge clk) begin
    if (reset) begin
      remain <= '0;
    end else if (trigger) begin
      remain <= pulse_len;
    end else if (running) begin
      remain <= remain - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse <= 1'b0;
    end else begin
      pulse <= trigger ? (pulse_len != '0) : (remain > 1);
    end
  end

  a_pulse_restart : assert property (@(posedge clk) disable iff (reset)
    trigger && (pulse_len > 2) |=> pulse ##1 pulse)
    else $error("Sync pulse did not restart on trigger.");

endmodule : qpc_pulse_stretch

// File: qpc_counter.sv
// Quadrature position counter: decoder, position counter, compare, timers.
// Assumes encoder pins are asynchronous; all control ports are on clk.
//
// Behaviour
// - Direction from phase relation, output flag
// - Count pulse on every phase edge
// - Count up forward, down reverse
// - Swap bit exchanges phase inputs
// - Overflow loads zero, underflow loads max
// - Overflow and underflow raise interrupt flags
// - Index mode: index loads zero or max
// - Max mode wraps at maximum and zero
// - Max mode wraps set overflow/underflow flags
// - First index mode: only first index loads
// - Index load acts at index edge
// - No phase error detection
// - Compare value always shadowed
// - Shadow loads on match or zero
// - Match gives sync pulse and flag
// - New match restarts sync pulse
// - Unit timer counts while enabled
// - Timer wraps at period, sets timeout
// - Timeout latches position value
// - Capture timer latched on unit event
// - Direction reversal sets change error
// - Capture overrange sets overflow error
// - Enable bits gate each interrupt source
module qpc_counter
  import qpc_pkg::*;
#(
  parameter int POS_W    = QPC_POS_W,
  parameter int TMR_W    = QPC_TMR_W,
  parameter int SYNC_W   = QPC_SYNC_W,
  parameter int CAPDIV_W = QPC_CAPDIV_W
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Encoder pins
  input  wire logic                      phase_a_input,
  input  wire logic                      phase_b_input,
  input  wire logic                      index_input,
  // Decoder and counter control
  input  wire logic                      swap_phases,
  input  wire qpc_mode_t                 counter_mode,
  input  wire logic [POS_W-1:0]          max_position_value,
  input  wire logic [POS_W-1:0]          initial_position_value,
  input  wire logic                      load_initial,
  // Position compare
  input  wire logic [POS_W-1:0]          position_compare_value,
  input  wire logic                      compare_write,
  input  wire logic                      shadow_load_on_zero,
  input  wire logic [SYNC_W-1:0]         sync_pulse_width,
  // Unit timer
  input  wire logic                      unit_timer_enable,
  input  wire logic [TMR_W-1:0]          unit_timer_period,
  // Capture unit
  input  wire logic [QPC_PRESCALE_W-1:0] unit_position_prescale,
  input  wire logic [CAPDIV_W-1:0]       capture_clock_prescale,
  input  wire logic                      capture_flags_clear,
  // Interrupt enables: direction, underflow, overflow, match, timeout
  input  wire logic [4:0]                interrupt_enable_reg,
  // Status outputs
  output logic                           direction_flag,
  output logic [POS_W-1:0]               position_count,
  output logic [POS_W-1:0]               position_latch_value,
  output logic [TMR_W-1:0]               unit_timer_count,
  output logic [QPC_CAP_W-1:0]           capture_timer_count,
  output logic [QPC_CAP_W-1:0]           capture_period_value,
  output logic                           capture_new_value,
  output logic                           direction_change_error_flag,
  output logic                           capture_overflow_error_flag,
  output logic                           first_index_seen,
  output logic [POS_W-1:0]               active_compare,
  // Event flags and interrupt
  output logic                           overflow_flag,
  output logic                           underflow_flag,
  output logic                           compare_flag,
  output logic                           unit_timeout_flag,
  output logic                           direction_change_flag,
  output logic                           compare_sync_output,
  output logic                           interrupt_out
);

  initial begin
    if (POS_W < 2 || TMR_W < 2 || SYNC_W < 2 || CAPDIV_W < 1) begin
      $error("qpc_counter: widths too small.");
    end
  end

  // -----------------------------------------------------------------------
  // Input synchronisers and decoder
  // -----------------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;

  // Not reset: the chain follows the pins during reset, so a phase that
  // rests high is not taken for an edge when reset is released.
  always_ff @(posedge clk) begin
    pin_meta <= {index_input, phase_b_input, phase_a_input};
    pin_sync <= pin_meta;
    pin_prev <= pin_sync;
  end

  wire decoder_phase_a  = swap_phases ? pin_sync[1] : pin_sync[0];
  wire decoder_phase_b  = swap_phases ? pin_sync[0] : pin_sync[1];
  wire prev_phase_a     = swap_phases ? pin_prev[1] : pin_prev[0];
  wire prev_phase_b     = swap_phases ? pin_prev[0] : pin_prev[1];
  wire edge_a           = decoder_phase_a ^ prev_phase_a;
  wire edge_b           = decoder_phase_b ^ prev_phase_b;
  // Ideal inputs are assumed, so a double edge is never judged an error.
  wire count_clock_pulse = edge_a | edge_b;
  // Forward when A leads B: an A edge makes A differ from B.
  wire forward_now      = edge_a ? (decoder_phase_a != decoder_phase_b)
                                 : (decoder_phase_a == decoder_phase_b);
  wire index_event      = pin_sync[2] & ~pin_prev[2];

  always_ff @(posedge clk) begin
    if (reset) begin
      direction_flag <= 1'b0;
    end else if (count_clock_pulse) begin
      direction_flag <= forward_now;
    end
  end

  // -----------------------------------------------------------------------
  // Position counter
  // -----------------------------------------------------------------------
  wire at_max       = (position_count >= max_position_value);
  wire at_zero      = (position_count == '0);
  wire index_mode   = (counter_mode == QPC_RESET_ON_INDEX);
  wire first_mode   = (counter_mode == QPC_RESET_ON_FIRST_INDEX);
  wire index_load   = index_event &&
                      (index_mode || (first_mode && !first_index_seen));
  wire cnt_up       = count_clock_pulse && forward_now;
  wire cnt_down     = count_clock_pulse && !forward_now;
  wire next_ovf     = !index_load && cnt_up && at_max;
  wire next_unf     = !index_load && cnt_down && at_zero;
  wire index_dir    = count_clock_pulse ? forward_now : direction_flag;

  logic [POS_W-1:0] next_position;

  always_comb begin
    next_position = position_count;
    if (load_initial) begin
      next_position = initial_position_value;
    end else if (index_load) begin
      next_position = index_dir ? '0 : max_position_value;
    end else if (next_ovf) begin
      next_position = '0;
    end else if (next_unf) begin
      next_position = max_position_value;
    end else if (cnt_up) begin
      next_position = position_count + 1'b1;
    end else if (cnt_down) begin
      next_position = position_count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      position_count   <= '0;
      first_index_seen <= 1'b0;
    end else begin
      position_count <= next_position;
      if (index_event && first_mode) begin
        first_index_seen <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Position compare with shadow
  // -----------------------------------------------------------------------
  logic [POS_W-1:0] shadow_compare;
  logic             shadow_pending;
  logic             pos_changed;

  always_ff @(posedge clk) begin
    if (reset) begin
      pos_changed <= 1'b0;
    end else begin
      pos_changed <= (next_position != position_count);
    end
  end

  wire compare_match = pos_changed && (position_count == active_compare);
  wire zero_event    = pos_changed && at_zero;
  wire shadow_move   = shadow_pending &&
                       (shadow_load_on_zero ? zero_event : compare_match);

  always_ff @(posedge clk) begin
    if (reset) begin
      shadow_compare <= '0;
      shadow_pending <= 1'b0;
      active_compare <= '0;
    end else begin
      if (compare_write) begin
        shadow_compare <= position_compare_value;
      end
      shadow_pending <= compare_write | (shadow_pending & ~shadow_move);
      if (shadow_move) begin
        active_compare <= shadow_compare;
      end
    end
  end

  qpc_pulse_stretch #(
    .WIDTH(SYNC_W)
  ) u_stretch (
    .clk      (clk),
    .reset    (reset),
    .trigger  (compare_match),
    .pulse_len(sync_pulse_width),
    .pulse    (compare_sync_output)
  );

  // -----------------------------------------------------------------------
  // Unit timer
  // -----------------------------------------------------------------------
  wire unit_timeout = unit_timer_enable && (unit_timer_count == unit_timer_period);

  always_ff @(posedge clk) begin
    if (reset) begin
      unit_timer_count     <= '0;
      position_latch_value <= '0;
    end else if (unit_timeout) begin
      unit_timer_count     <= '0;
      position_latch_value <= position_count;
    end else if (unit_timer_enable) begin
      unit_timer_count <= unit_timer_count + 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Capture unit
  // -----------------------------------------------------------------------
  logic [15:0]         upe_count;
  logic [CAPDIV_W-1:0] cap_div;
  logic                upe_dir;
  logic                dir_seen_change;
  logic                cap_overrange;

  wire [15:0] upe_mask = 16'(({16'h0000, 16'h0001} << unit_position_prescale) - 1);
  wire        upe_hit  = count_clock_pulse && ((upe_count & upe_mask) == upe_mask);
  wire capture_timer_clock = (cap_div == capture_clock_prescale);
  wire dir_changed = count_clock_pulse && (forward_now != direction_flag);

  always_ff @(posedge clk) begin
    if (reset) begin
      upe_count <= 16'h0000;
      cap_div   <= '0;
    end else begin
      if (count_clock_pulse) begin
        upe_count <= upe_hit ? 16'h0000 : upe_count + 16'h0001;
      end
      cap_div <= capture_timer_clock ? '0 : cap_div + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      capture_timer_count <= QPC_CAP_RESET;
      capture_period_value <= QPC_CAP_RESET;
      cap_overrange <= 1'b0;
      dir_seen_change <= 1'b0;
      upe_dir <= 1'b0;
    end else if (upe_hit) begin
      capture_timer_count  <= QPC_CAP_RESET;
      capture_period_value <= capture_timer_count;
      cap_overrange        <= 1'b0;
      dir_seen_change      <= 1'b0;
      upe_dir              <= forward_now;
    end else begin
      if (capture_timer_clock && capture_timer_count == QPC_CAP_MAX) begin
        cap_overrange <= 1'b1;
      end
      if (capture_timer_clock) begin
        capture_timer_count <= capture_timer_count + 16'h0001;
      end
      if (dir_changed) begin
        dir_seen_change <= 1'b1;
      end
    end
  end

  // Error flags are sticky; an event in the clearing cycle wins.
  always_ff @(posedge clk) begin
    if (reset) begin
      capture_new_value           <= 1'b0;
      direction_change_error_flag <= 1'b0;
      capture_overflow_error_flag <= 1'b0;
    end else begin
      capture_new_value <= upe_hit | (capture_new_value & ~capture_flags_clear);
      direction_change_error_flag <= (upe_hit && (dir_seen_change || dir_changed))
        | (direction_change_error_flag & ~capture_flags_clear);
      capture_overflow_error_flag <= (upe_hit && cap_overrange)
        | (capture_overflow_error_flag & ~capture_flags_clear);
    end
  end

  // -----------------------------------------------------------------------
  // Event flags and interrupt
  // -----------------------------------------------------------------------
  // Flags last one cycle so software never needs to clear them.
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_flag         <= 1'b0;
      underflow_flag        <= 1'b0;
      compare_flag          <= 1'b0;
      unit_timeout_flag     <= 1'b0;
      direction_change_flag <= 1'b0;
    end else begin
      overflow_flag         <= next_ovf;
      underflow_flag        <= next_unf;
      compare_flag          <= compare_match;
      unit_timeout_flag     <= unit_timeout;
      direction_change_flag <= dir_changed;
    end
  end

  wire [4:0] flag_vec = {unit_timeout_flag, compare_flag, overflow_flag,
                         underflow_flag, direction_change_flag};
  assign interrupt_out = |(flag_vec & interrupt_enable_reg);

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  a_count_up_step : assert property (@(posedge clk) disable iff (reset)
    cnt_up && !at_max && !index_load && !load_initial
    |=> position_count == $past(position_count) + 1'b1)
    else $error("Position did not increment.");

  a_overflow_wrap : assert property (@(posedge clk) disable iff (reset)
    next_ovf && !load_initial |=> position_count == '0 && overflow_flag)
    else $error("Overflow did not wrap to zero.");

  a_underflow_wrap : assert property (@(posedge clk) disable iff (reset)
    next_unf && !load_initial |=> position_count == $past(max_position_value)
    && underflow_flag)
    else $error("Underflow did not wrap to maximum.");

  a_index_load : assert property (@(posedge clk) disable iff (reset)
    index_load && !load_initial && index_dir |=> position_count == '0)
    else $error("Index event did not clear position.");

  a_timer_hold : assert property (@(posedge clk) disable iff (reset)
    !unit_timer_enable |=> $stable(unit_timer_count))
    else $error("Unit timer moved while disabled.");

  a_timeout_latch : assert property (@(posedge clk) disable iff (reset)
    unit_timeout |=> position_latch_value == $past(position_count)
    && unit_timer_count == '0 && unit_timeout_flag)
    else $error("Timeout did not latch position.");

  a_flag_one_cycle : assert property (@(posedge clk) disable iff (reset)
    overflow_flag |=> !overflow_flag)
    else $error("Overflow flag lasted more than one cycle.");

  a_capture_latch : assert property (@(posedge clk) disable iff (reset)
    upe_hit |=> capture_period_value == $past(capture_timer_count)
    && capture_new_value)
    else $error("Capture value not latched.");

  a_first_index_once : assert property (@(posedge clk) disable iff (reset)
    first_mode && first_index_seen && index_event && !count_clock_pulse && !load_initial
    |=> position_count == $past(position_count))
    else $error("Index reloaded after the first one.");

  c_overflow  : cover property (@(posedge clk) disable iff (reset) next_ovf);
  c_underflow : cover property (@(posedge clk) disable iff (reset) next_unf);
  c_match     : cover property (@(posedge clk) disable iff (reset) compare_match);
  c_capture   : cover property (@(posedge clk) disable iff (reset) upe_hit);

endmodule : qpc_counter

// File: qpc_encoder_model.sv
// Behavioural quadrature encoder with index track, facing the position counter.
// Assumes the bench calls move and index_pulse; pins change just after a rising edge.
module qpc_encoder_model (
  // Clock
  input  wire logic clk,
  // Encoder pins
  output logic      phase_a,
  output logic      phase_b,
  output logic      index
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // Quadrature state
  // ---------------------------------------------------------------------
  logic [1:0] state;

  // Gray order keeps phase A a quarter cycle ahead of B in forward motion.
  assign phase_a = state[0] ^ state[1];
  assign phase_b = state[1];

  initial begin
    state = 2'h0;
    index = 1'b0;
  end

  // One quadrature step, then a quiet gap so edges never crowd the sampler.
  task automatic move(input logic fwd, input int gap);
    @(posedge clk);
    state <= fwd ? state + 2'h1 : state - 2'h1;
    repeat (gap) @(posedge clk);
  endtask : move

  task automatic index_pulse();
    @(posedge clk);
    index <= 1'b1;
    repeat (3) @(posedge clk);
    index <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : index_pulse
endmodule : qpc_encoder_model

// File: test_qpc_counter.sv
// Self-checking bench for the quadrature position counter.
// Assumes qpc_pkg and the encoder model are compiled first; one 100 MHz clock.
module test_qpc_counter
  import qpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic        clk, reset, phase_a_input, phase_b_input, index_input;
  logic        swap_phases, load_initial, compare_write, shadow_load_on_zero;
  logic        unit_timer_enable, capture_flags_clear;
  qpc_mode_t   counter_mode;
  logic [31:0] max_position_value, initial_position_value, position_compare_value;
  logic [31:0] unit_timer_period, position_count, position_latch_value;
  logic [31:0] unit_timer_count, active_compare, exp_pos, hold;
  logic [15:0] sync_pulse_width, capture_timer_count, capture_period_value;
  logic [3:0]  unit_position_prescale;
  logic [2:0]  capture_clock_prescale;
  logic [4:0]  interrupt_enable_reg;
  logic        direction_flag, capture_new_value, direction_change_error_flag;
  logic        capture_overflow_error_flag, first_index_seen, overflow_flag;
  logic        underflow_flag, compare_flag, unit_timeout_flag, direction_change_flag;
  logic        compare_sync_output, interrupt_out, exp_dir;
  int          err_count, cmp_count, sync_len, sync_cnt, ut_prev, ut_cnt, cyc, n;

  typedef struct packed {
    logic [31:0] pos;
    logic        ovf;
    logic        unf;
    logic        dir;
  } qpc_note_t;
  qpc_note_t notes[$];

  qpc_counter u_qpc_counter (.clk, .reset, .phase_a_input, .phase_b_input, .index_input,
    .swap_phases, .counter_mode, .max_position_value, .initial_position_value,
    .load_initial, .position_compare_value, .compare_write, .shadow_load_on_zero,
    .sync_pulse_width, .unit_timer_enable, .unit_timer_period, .unit_position_prescale,
    .capture_clock_prescale, .capture_flags_clear, .interrupt_enable_reg, .direction_flag,
    .position_count, .position_latch_value, .unit_timer_count, .capture_timer_count,
    .capture_period_value, .capture_new_value, .direction_change_error_flag,
    .capture_overflow_error_flag, .first_index_seen, .active_compare, .overflow_flag,
    .underflow_flag, .compare_flag, .unit_timeout_flag, .direction_change_flag,
    .compare_sync_output, .interrupt_out);

  qpc_encoder_model u_qpc_encoder_model (.clk(clk), .phase_a(phase_a_input),
    .phase_b(phase_b_input), .index(index_input));

  always #5 clk = ~clk;

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Notes the count, wrap flags and direction that one encoder step must give.
  task automatic step(input logic fwd);
    qpc_note_t nt;
    nt.dir = fwd ^ swap_phases;
    nt.ovf = nt.dir && exp_pos == max_position_value;
    nt.unf = !nt.dir && exp_pos == 32'h0000_0000;
    exp_pos = nt.ovf ? 32'h0000_0000 : nt.unf ? max_position_value :
              nt.dir ? exp_pos + 32'h0000_0001 : exp_pos - 32'h0000_0001;
    nt.pos = exp_pos;
    exp_dir = nt.dir;
    notes.push_back(nt);
    u_qpc_encoder_model.move(fwd, 5);
  endtask : step

  task automatic index_load(input logic [31:0] v);
    exp_pos = v;
    notes.push_back({v, 1'b0, 1'b0, exp_dir});
    u_qpc_encoder_model.index_pulse();
  endtask : index_load

  task automatic tend(input string name);
    $display("Test %s finished", name);
  endtask : tend

  // ---------------------------------------------------------------------
  // Output watcher
  // ---------------------------------------------------------------------
  always @(posedge clk) begin : watch
    qpc_note_t nt;
    if (!reset) begin
      if (position_count !== exp_pos && notes.size() == 0) begin
        check("unexpected count", exp_pos, position_count);
      end
      if (notes.size() != 0 && position_count === notes[0].pos) begin
        nt = notes.pop_front();
        check("overflow", nt.ovf, overflow_flag);
        check("underflow", nt.unf, underflow_flag);
        check("direction", nt.dir, direction_flag);
      end
      if ({unit_timeout_flag, compare_flag, overflow_flag, underflow_flag,
           direction_change_flag} !== 5'h0) begin
        check("interrupt", |({unit_timeout_flag, compare_flag, overflow_flag, underflow_flag,
              direction_change_flag} & interrupt_enable_reg), interrupt_out);
      end
      if (compare_sync_output === 1'b1) begin
        if (sync_len == 0) check("compare flag", 32'h1, compare_flag);
        sync_len++;
      end else if (sync_len != 0) begin
        check("sync width", sync_pulse_width, sync_len);
        sync_len = 0;
        sync_cnt++;
      end
      if (unit_timeout_flag === 1'b1) begin
        if (ut_prev >= 0) check("unit period", unit_timer_period + 1, cyc - ut_prev);
        check("latched position", exp_pos, position_latch_value);
        ut_prev = cyc;
        ut_cnt++;
      end
      if (unit_timer_enable !== 1'b1) ut_prev = -1;
      cyc++;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_sim();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    {clk, reset, swap_phases, load_initial, compare_write, shadow_load_on_zero} = 6'h01 << 4;
    {unit_timer_enable, capture_flags_clear, exp_dir} = 3'h0;
    {initial_position_value, position_compare_value, exp_pos} = 96'h0;
    {err_count, cmp_count, sync_len, sync_cnt, ut_cnt, cyc} = 192'h0;
    ut_prev = -1;
    counter_mode = QPC_RESET_ON_FIRST_INDEX;
    max_position_value = 32'h0000_0004;
    unit_timer_period = 32'h0000_0005;
    sync_pulse_width = 16'h0003;
    {unit_position_prescale, capture_clock_prescale, interrupt_enable_reg} = 12'h0;
    void'($urandom(47916));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    interrupt_enable_reg <= 5'($urandom);
    @(posedge clk);
    check("reset count", 32'h0, position_count);
    check("reset direction", 32'h0, direction_flag);
    for (int i = 0; i < 3; i++) step(1'b1);
    index_load(32'h0000_0000);
    step(1'b1);
    u_qpc_encoder_model.index_pulse();
    check("first index seen", 32'h1, first_index_seen);
    tend("first_index");
    counter_mode <= QPC_RESET_ON_MAX;
    n = 6 + $urandom % 6;
    for (int i = 0; i < n; i++) step(1'b1);
    for (int i = 0; i < n + 3; i++) step(1'b0);
    hold = 32'h1 + $urandom % 4;
    if (hold != exp_pos) notes.push_back({hold, 1'b0, 1'b0, exp_dir});
    exp_pos = hold;
    @(posedge clk);
    initial_position_value <= hold;
    load_initial <= 1'b1;
    @(posedge clk);
    load_initial <= 1'b0;
    repeat (5) @(posedge clk);
    tend("max_wrap");
    if (u_qpc_encoder_model.state[0]) step(1'b1);
    swap_phases <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) step(1'b1);
    swap_phases <= 1'b0;
    repeat (2) @(posedge clk);
    tend("swap");
    counter_mode <= QPC_RESET_ON_INDEX;
    step(1'b0);
    if (exp_pos == max_position_value) step(1'b0);
    index_load(max_position_value);
    tend("index_reverse");
    counter_mode <= QPC_RESET_ON_MAX;
    if (exp_pos == 32'h0) step(1'b1);
    n = sync_cnt;
    position_compare_value <= 32'h0000_0002;
    shadow_load_on_zero <= 1'b1;
    compare_write <= 1'b1;
    @(posedge clk);
    compare_write <= 1'b0;
    repeat (2) @(posedge clk);
    check("active before zero", 32'h0, active_compare);
    while (exp_pos != 32'h0) step(1'b1);
    repeat (3) @(posedge clk);
    check("active after zero", 32'h2, active_compare);
    step(1'b1);
    step(1'b1);
    repeat (6) @(posedge clk);
    check("sync pulses", 32'h1, sync_cnt > n + 1);
    tend("compare");
    unit_timer_period <= 32'h5 + $urandom % 8;
    unit_timer_enable <= 1'b1;
    repeat (60) @(posedge clk);
    unit_timer_enable <= 1'b0;
    repeat (2) @(posedge clk);
    hold = unit_timer_count;
    repeat (10) @(posedge clk);
    check("timer hold", hold, unit_timer_count);
    check("timeouts seen", 32'h1, ut_cnt >= 3);
    tend("unit_timer");
    if (u_qpc_encoder_model.state == 2'h0) step(1'b1);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    exp_pos = 32'h0;
    repeat (6) @(posedge clk);
    check("count after reset", 32'h0, position_count);
    check("direction after reset", 32'h0, direction_flag);
    tend("mid_reset");
    unit_position_prescale <= 4'h1;
    capture_flags_clear <= 1'b1;
    @(posedge clk);
    capture_flags_clear <= 1'b0;
    for (int i = 0; i < 4; i++) step(1'b1);
    check("capture new", 32'h1, capture_new_value);
    check("capture period", 32'h0000_000B, capture_period_value);
    capture_flags_clear <= 1'b1;
    @(posedge clk);
    capture_flags_clear <= 1'b0;
    step(1'b1);
    check("direction error", 32'h0, direction_change_error_flag);
    step(1'b0);
    check("direction error", 32'h1, direction_change_error_flag);
    tend("capture");
    check("pending notes", 32'h0, notes.size());
    end_sim();
  end
endmodule : test_qpc_counter
